/* File: rtl/serial_lowside_driver_ctrl.sv */
`timescale 1ns/1ps

module serial_lowside_driver_ctrl #(
    parameter int CHANNELS           = lowside_pkg::CHANNELS,
    parameter int OC_DEGLITCH_CYCLES = lowside_pkg::OC_DEGLITCH_CYCLES,
    parameter int OL_DEGLITCH_CYCLES = lowside_pkg::OL_DEGLITCH_CYCLES,
    parameter int RETRY_CYCLES       = lowside_pkg::RETRY_CYCLES
) (
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic                sclk,
    input  wire logic                serial_data_in,
    input  wire logic                transfer_strobe,
    input  wire logic                output_enable_n,
    input  wire logic                device_reset,
    input  wire logic                thermal_shutdown,
    input  wire logic                undervoltage_lockout,
    input  wire logic [CHANNELS-1:0] current_limit,
    input  wire logic [CHANNELS-1:0] open_load_sense,
    output      logic [CHANNELS-1:0] channel_on,
    output      logic                serial_data_out,
    output      logic                fault_flag_n_out,
    output      logic                fault_flag_n_oe,
    output      logic [CHANNELS-1:0] overcurrent_flag,
    output      logic [CHANNELS-1:0] open_load_flag
);

    ////////////////////////////////////////////////////////////////////////
    // parameter checks

    localparam int TW = $clog2(RETRY_CYCLES + 1);
    localparam int SW = 7 + 2 * CHANNELS;

    generate
        if (CHANNELS != 4)
        begin : g_bad_channels
            $error("channel count must be four");
        end
        if (OC_DEGLITCH_CYCLES < 2 || OL_DEGLITCH_CYCLES < 2)
        begin : g_bad_deglitch
            $error("deglitch counts must be at least two");
        end
        if (RETRY_CYCLES < OC_DEGLITCH_CYCLES ||
            RETRY_CYCLES < OL_DEGLITCH_CYCLES)
        begin : g_bad_retry
            $error("retry count must be the longest count");
        end
    endgenerate

    localparam logic [TW-1:0] OC_LIMIT    = TW'(OC_DEGLITCH_CYCLES);
    localparam logic [TW-1:0] OL_LIMIT    = TW'(OL_DEGLITCH_CYCLES);
    localparam logic [TW-1:0] RETRY_LIMIT = TW'(RETRY_CYCLES);
    localparam logic [TW-1:0] TIMER_ONE   = TW'(1);
    localparam logic [TW-1:0] TIMER_ZERO  = TW'(0);

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers

    logic [SW-1:0]       raw_in;
    logic [SW-1:0]       sync_in;
    logic                sclk_s;
    logic                sdi_s;
    logic                strobe_s;
    logic                enable_n_s;
    logic                dev_reset_s;
    logic                tsd_s;
    logic                undervoltage_lockout_s;
    logic [CHANNELS-1:0] limit_s;
    logic [CHANNELS-1:0] low_volt_s;

    assign raw_in = {sclk, serial_data_in, transfer_strobe,
                     output_enable_n, device_reset, thermal_shutdown,
                     undervoltage_lockout, current_limit,
                     open_load_sense};

    sync_2ff #(
        .WIDTH (SW)
    ) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .d      (raw_in),
        .q      (sync_in)
    );

    assign {sclk_s, sdi_s, strobe_s, enable_n_s, dev_reset_s, tsd_s,
            undervoltage_lockout_s, limit_s, low_volt_s} = sync_in;

    ////////////////////////////////////////////////////////////////////////
    // edge detection and soft clear

    logic sclk_d;
    logic strobe_d;
    logic sclk_rise;
    logic sclk_fall;
    logic strobe_rise;
    logic clear;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sclk_d   <= 1'b0;
            strobe_d <= 1'b0;
        end
        else
        begin
            sclk_d   <= sclk_s;
            strobe_d <= strobe_s;
        end
    end

    assign sclk_rise   = sclk_s & ~sclk_d;
    assign sclk_fall   = ~sclk_s & sclk_d;
    assign strobe_rise = strobe_s & ~strobe_d;

    // reset pin or low supply wipes phase, shift, stage, counters, flags and drive, not edge detectors
    assign clear = dev_reset_s | undervoltage_lockout_s;

    ////////////////////////////////////////////////////////////////////////
    // serial phase tracking

    lowside_pkg::phase_t phase;
    lowside_pkg::phase_t next_phase;

    always_comb
    begin
        next_phase = phase;
        unique case (phase)
            lowside_pkg::PHASE_WRITE:
            begin
                if (strobe_rise)
                begin
                    next_phase = lowside_pkg::PHASE_LOAD_PENDING;
                end
            end
            lowside_pkg::PHASE_LOAD_PENDING:
            begin
                if (!strobe_s)
                begin
                    next_phase = lowside_pkg::PHASE_WRITE;
                end
                else if (sclk_fall)
                begin
                    next_phase = lowside_pkg::PHASE_READ;
                end
            end
            lowside_pkg::PHASE_READ:
            begin
                if (!strobe_s)
                begin
                    next_phase = lowside_pkg::PHASE_WRITE;
                end
            end
            default:
            begin
                next_phase = lowside_pkg::PHASE_WRITE;
            end
        endcase
    end

    // power-up reset comes from resetn alone
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            phase <= lowside_pkg::PHASE_WRITE;
        end
        else if (clear)
        begin
            phase <= lowside_pkg::PHASE_WRITE;
        end
        else
        begin
            phase <= next_phase;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // holding shift register and output stage

    logic [CHANNELS-1:0] shift_reg;
    logic [CHANNELS-1:0] stage;
    logic [CHANNELS-1:0] fault_bit;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            shift_reg <= lowside_pkg::SHIFT_RESET;
        end
        else if (clear)
        begin
            shift_reg <= lowside_pkg::SHIFT_RESET;
        end
        else if (sclk_rise && !strobe_s)
        begin
            shift_reg <= {shift_reg[CHANNELS-2:0], sdi_s};
        end
        else if (sclk_fall && strobe_s &&
                 phase == lowside_pkg::PHASE_LOAD_PENDING)
        begin
            shift_reg <= fault_bit;
        end
        else if (sclk_fall && phase == lowside_pkg::PHASE_READ)
        begin
            shift_reg <= {shift_reg[CHANNELS-2:0], sdi_s};
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stage <= lowside_pkg::STAGE_RESET;
        end
        else if (clear)
        begin
            stage <= lowside_pkg::STAGE_RESET;
        end
        else if (strobe_rise)
        begin
            stage <= shift_reg;
        end
    end

    // last stage feeds the next device in a chain
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            serial_data_out <= lowside_pkg::SDO_RESET;
        end
        else
        begin
            serial_data_out <= shift_reg[CHANNELS-1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-channel protection and drive

    logic [CHANNELS-1:0] oc_flag;
    logic [CHANNELS-1:0] ol_flag;
    logic [CHANNELS-1:0] oc_trip;
    logic [CHANNELS-1:0] ol_trip;
    logic [CHANNELS-1:0] retry_done;

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++)
        begin : g_channel
            logic [TW-1:0] oc_count;
            logic [TW-1:0] ol_count;
            logic [TW-1:0] retry_count;

            // current limit must persist past the deglitch time
            assign oc_trip[ch] = channel_on[ch] & limit_s[ch] &
                                 (oc_count == OC_LIMIT);
            assign ol_trip[ch] = ~stage[ch] & low_volt_s[ch] &
                                 (ol_count == OL_LIMIT);
            assign retry_done[ch] = (retry_count == TIMER_ONE);

            always_ff @(posedge clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    oc_count <= TIMER_ZERO;
                end
                else if (clear)
                begin
                    oc_count <= TIMER_ZERO;
                end
                else if (channel_on[ch] && limit_s[ch] &&
                         oc_count != OC_LIMIT)
                begin
                    oc_count <= oc_count + TIMER_ONE;
                end
                else if (!(channel_on[ch] && limit_s[ch]))
                begin
                    oc_count <= TIMER_ZERO;
                end
            end

            always_ff @(posedge clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    retry_count <= TIMER_ZERO;
                end
                else if (clear)
                begin
                    retry_count <= TIMER_ZERO;
                end
                else if (oc_trip[ch])
                begin
                    retry_count <= RETRY_LIMIT;
                end
                else if (!stage[ch])
                begin
                    retry_count <= TIMER_ZERO;
                end
                else if (retry_count != TIMER_ZERO)
                begin
                    retry_count <= retry_count - TIMER_ONE;
                end
            end

            // set wins over retry and stage clears in the same cycle, soft clear wins over set
            always_ff @(posedge clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    oc_flag[ch] <= 1'b0;
                end
                else if (clear)
                begin
                    oc_flag[ch] <= 1'b0;
                end
                else if (oc_trip[ch])
                begin
                    oc_flag[ch] <= 1'b1;
                end
                else if (retry_done[ch])
                begin
                    oc_flag[ch] <= 1'b0;
                end
                else if (!stage[ch])
                begin
                    oc_flag[ch] <= 1'b0;
                end
            end

            always_ff @(posedge clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    ol_count <= TIMER_ZERO;
                end
                else if (clear)
                begin
                    ol_count <= TIMER_ZERO;
                end
                else if (!stage[ch] && low_volt_s[ch] &&
                         ol_count != OL_LIMIT)
                begin
                    ol_count <= ol_count + TIMER_ONE;
                end
                else if (!(!stage[ch] && low_volt_s[ch]))
                begin
                    ol_count <= TIMER_ZERO;
                end
            end

            always_ff @(posedge clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    ol_flag[ch] <= 1'b0;
                end
                else if (clear)
                begin
                    ol_flag[ch] <= 1'b0;
                end
                else if (ol_trip[ch])
                begin
                    ol_flag[ch] <= 1'b1;
                end
                else if (stage[ch])
                begin
                    ol_flag[ch] <= 1'b0;
                end
            end

            // each channel conducts on its own stage bit
            always_ff @(posedge clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    channel_on[ch] <= 1'b0;
                end
                else if (clear)
                begin
                    channel_on[ch] <= 1'b0;
                end
                else
                begin
                    channel_on[ch] <= stage[ch] & ~enable_n_s &
                                      ~tsd_s &
                                      ~oc_flag[ch] &
                                      ~oc_trip[ch];
                end
            end
        end
    endgenerate

    assign fault_bit        = oc_flag | ol_flag;
    assign overcurrent_flag = oc_flag;
    assign open_load_flag   = ol_flag;

    ////////////////////////////////////////////////////////////////////////
    // open-drain fault pin

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fault_flag_n_oe  <= 1'b0;
            fault_flag_n_out <= 1'b0;
        end
        else
        begin
            fault_flag_n_oe  <= (|fault_bit) | tsd_s;
            fault_flag_n_out <= 1'b0;
        end
    end

endmodule : serial_lowside_driver_ctrl

/* File: rtl/lowside_pkg.sv */
// Operation
// - rising shift clock shifts data while strobe low
// - last shift stage drives the serial output
// - strobe rise copies shift register to outputs
// - four channels, each with its own bit
// - lasting current limit disables channel, flags fault
// - overcurrent clears itself after the retry interval
// - reset or supply loss clears overcurrent at once
// - overheating disables all outputs, flags fault
// - undervoltage resets logic and disables everything
// - off channel held low sets open-load flag
// - open-load flag clears while output bit set
// - overcurrent flag clears when output bit cleared
// - per-channel fault bit is overcurrent or open-load
// - first falling clock after strobe loads faults
// - readout shifts on each falling shift clock
// - fault pin low on any flag or overheating
// - enable gates channels, serial logic keeps running
// - reset input clears logic and serial registers
// - internal power-up reset, no reset pulse needed; the code takes its power-up reset from resetn
// - open-load qualified by a 15 us deglitch
package lowside_pkg;

    localparam int CHANNELS       = 4;
    localparam int CLK_PERIOD_NS  = 10;

    localparam int OC_DEGLITCH_NS = 3500;
    localparam int OL_DEGLITCH_NS = 15000;
    localparam int RETRY_NS       = 1200000;

    localparam int OC_DEGLITCH_CYCLES =
        (OC_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OL_DEGLITCH_CYCLES =
        (OL_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RETRY_CYCLES =
        (RETRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [3:0] SHIFT_RESET = 4'h0;
    localparam logic [3:0] STAGE_RESET = 4'h0;
    localparam logic       SDO_RESET   = 1'b0;

    typedef enum logic [1:0]
    {
        PHASE_WRITE,
        PHASE_LOAD_PENDING,
        PHASE_READ
    } phase_t;

endpackage : lowside_pkg

/* File: rtl/sync_2ff.sv */
`timescale 1ns/1ps

module sync_2ff #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] d,
    output      logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta <= '0;
            q    <= '0;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule : sync_2ff

/* File: tb/lowside_checker_assertions.sv */
`timescale 1ns/1ps

module lowside_checker #(
    parameter int CHANNELS           = 4,
    parameter int OC_DEGLITCH_CYCLES = 10
) (
    input wire logic                clk,
    input wire logic                resetn,
    input wire logic                output_enable_n,
    input wire logic                device_reset,
    input wire logic                thermal_shutdown,
    input wire logic                undervoltage_lockout,
    input wire logic [CHANNELS-1:0] current_limit,
    input wire logic [CHANNELS-1:0] channel_on,
    input wire logic                serial_data_out,
    input wire logic                fault_flag_n_out,
    input wire logic                fault_flag_n_oe,
    input wire logic [CHANNELS-1:0] overcurrent_flag,
    input wire logic [CHANNELS-1:0] open_load_flag
);
    logic [2:0] cl_dly;
    int         oc_run;

    // run length of current limit on channel 0, seen through a delay
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cl_dly <= 3'h0;
            oc_run <= 0;
        end
        else
        begin
            cl_dly <= {cl_dly[1:0], current_limit[0]};
            oc_run <= cl_dly[2] ? oc_run + 1 : 0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////////
    pin_low_a: assert property (fault_flag_n_out == 1'b0)
        else $error("fault pin driven high");
    flag_pin_a: assert property (!device_reset && !undervoltage_lockout
        && (|overcurrent_flag || |open_load_flag) |=> fault_flag_n_oe)
        else $error("flag set but fault pin released");
    tsd_off_a: assert property (thermal_shutdown [*5]
        |-> channel_on == 4'h0 && fault_flag_n_oe)
        else $error("overheat left a channel on");
    en_off_a: assert property (output_enable_n [*5]
        |-> channel_on == 4'h0)
        else $error("disabled channel still on");
    uv_clear_a: assert property (undervoltage_lockout [*6]
        |-> channel_on == 4'h0 && overcurrent_flag == 4'h0
        && open_load_flag == 4'h0 && !serial_data_out)
        else $error("undervoltage did not clear logic");
    rst_clear_a: assert property (device_reset [*6]
        |-> channel_on == 4'h0 && overcurrent_flag == 4'h0 && !serial_data_out)
        else $error("reset input did not clear logic");
    oc_off_a: assert property ($rose(overcurrent_flag[0])
        |-> ##[0:1] !channel_on[0])
        else $error("overcurrent left channel on");
    oc_glitch_a: assert property ($rose(overcurrent_flag[0])
        |-> oc_run >= OC_DEGLITCH_CYCLES - 3)
        else $error("overcurrent tripped before deglitch");
    ol_on_a: assert property ($rose(channel_on[1])
        |-> ##[0:2] !open_load_flag[1])
        else $error("open-load flag kept with channel on");
    ol_off_a: assert property ($rose(open_load_flag[1]) |-> !channel_on[1])
        else $error("open-load flag set on a driven channel");

    oc_cover_c: cover property ($fell(overcurrent_flag[0]));
    ol_cover_c: cover property ($rose(open_load_flag[1]));
    tsd_cover_c: cover property (thermal_shutdown && fault_flag_n_oe);
endmodule : lowside_checker

bind serial_lowside_driver_ctrl lowside_checker #(
    .CHANNELS           (CHANNELS),
    .OC_DEGLITCH_CYCLES (OC_DEGLITCH_CYCLES)
) checker_i (
    .clk                  (clk),
    .resetn               (resetn),
    .output_enable_n      (output_enable_n),
    .device_reset         (device_reset),
    .thermal_shutdown     (thermal_shutdown),
    .undervoltage_lockout (undervoltage_lockout),
    .current_limit        (current_limit),
    .channel_on           (channel_on),
    .serial_data_out      (serial_data_out),
    .fault_flag_n_out     (fault_flag_n_out),
    .fault_flag_n_oe      (fault_flag_n_oe),
    .overcurrent_flag     (overcurrent_flag),
    .open_load_flag       (open_load_flag)
);

/* File: tb/serial_host_model.sv */
`timescale 1ns/1ps

module serial_host_model (
    output      logic sclk,
    output      logic serial_data_in,
    output      logic transfer_strobe,
    input  wire logic serial_data_out
);
    localparam int HALF_NS = 80;

    // link clock stands low and data sits at its pulldown level
    initial
    begin
        sclk            = 1'b0;
        serial_data_in  = 1'b0;
        transfer_strobe = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // non-blocking drive keeps pin changes that land on a core clock edge from racing it
    task automatic write_bits(input logic [7:0] bits, input int n);
        transfer_strobe <= 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_data_in <= bits[i];
            #HALF_NS sclk <= 1'b1;
            #HALF_NS sclk <= 1'b0;
        end
        serial_data_in <= 1'b0;
        #480 transfer_strobe <= 1'b1;
        #240;
    endtask : write_bits

    task automatic read_bits(output logic [3:0] bits);
        for (int i = 3; i >= 0; i--)
        begin
            #HALF_NS sclk <= 1'b1;
            #HALF_NS sclk <= 1'b0;
            #HALF_NS bits[i] = serial_data_out;
        end
    endtask : read_bits
endmodule : serial_host_model

/* File: tb/serial_lowside_driver_ctrl_tb.sv */
`timescale 1ns/1ps

module serial_lowside_driver_ctrl_tb;
    localparam int LIMIT = 20000;

    typedef struct packed {
        logic [7:0] bits;
        logic [3:0] nbits;
        logic       en_n;
        logic [3:0] exp_ch;
        logic       exp_sdo;
    } row_t;

    localparam row_t ROWS [6] = '{
        '{8'h05, 4'h4, 1'b0, 4'h5, 1'b0},
        '{8'h0A, 4'h4, 1'b0, 4'hA, 1'b1},
        '{8'h0F, 4'h4, 1'b1, 4'h0, 1'b1},
        '{8'h09, 4'h4, 1'b0, 4'h9, 1'b1},
        '{8'h3C, 4'h8, 1'b0, 4'hC, 1'b1},
        '{8'hA3, 4'h8, 1'b0, 4'h3, 1'b0}
    };

    logic       clk                  = 1'b0;
    logic       resetn               = 1'b0;
    logic       output_enable_n      = 1'b0;
    logic       device_reset         = 1'b0;
    logic       thermal_shutdown     = 1'b0;
    logic       undervoltage_lockout = 1'b0;
    logic [3:0] current_limit        = 4'h0;
    logic [3:0] open_load_sense      = 4'h0;
    wire logic  sclk;
    wire logic  serial_data_in;
    wire logic  transfer_strobe;
    logic       serial_data_out;
    logic       fault_flag_n_out;
    logic       fault_flag_n_oe;
    logic [3:0] channel_on;
    logic [3:0] overcurrent_flag;
    logic [3:0] open_load_flag;
    logic [3:0] rd;
    int         num_errors = 0;
    int         n_checks   = 0;
    int         cycles     = 0;

    always #5 clk = ~clk;

    serial_lowside_driver_ctrl #(
        .OC_DEGLITCH_CYCLES (10),
        .OL_DEGLITCH_CYCLES (20),
        .RETRY_CYCLES       (200)
    ) dut (
        .clk                  (clk),
        .resetn               (resetn),
        .sclk                 (sclk),
        .serial_data_in       (serial_data_in),
        .transfer_strobe      (transfer_strobe),
        .output_enable_n      (output_enable_n),
        .device_reset         (device_reset),
        .thermal_shutdown     (thermal_shutdown),
        .undervoltage_lockout (undervoltage_lockout),
        .current_limit        (current_limit),
        .open_load_sense      (open_load_sense),
        .channel_on           (channel_on),
        .serial_data_out      (serial_data_out),
        .fault_flag_n_out     (fault_flag_n_out),
        .fault_flag_n_oe      (fault_flag_n_oe),
        .overcurrent_flag     (overcurrent_flag),
        .open_load_flag       (open_load_flag)
    );

    serial_host_model host (
        .sclk            (sclk),
        .serial_data_in  (serial_data_in),
        .transfer_strobe (transfer_strobe),
        .serial_data_out (serial_data_out)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test

    task automatic chk4(input string what, input logic [3:0] exp,
                        input logic [3:0] got);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk4

    task automatic chk1(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_clk

    task automatic wait_oc(input int idx);
        for (int k = 0; k < 100 && overcurrent_flag[idx] !== 1'b1; k++)
            @(negedge clk);
        chk1("overcurrent_flag", 1'b1, overcurrent_flag[idx]);
    endtask : wait_oc

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            num_errors++;
            stop_test();
        end
    end

    initial
    begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        wait_clk(40);
        chk4("channel_on", 4'h0, channel_on);
        chk1("fault_flag_n_oe", 1'b0, fault_flag_n_oe);
        foreach (ROWS[i])
        begin
            @(posedge clk) output_enable_n <= ROWS[i].en_n;
            host.write_bits(ROWS[i].bits, int'(ROWS[i].nbits));
            wait_clk(10);
            chk4("channel_on", ROWS[i].exp_ch, channel_on);
            chk1("sdo", ROWS[i].exp_sdo, serial_data_out);
        end
        $display("test table done");

        host.write_bits(8'h01, 4);
        @(posedge clk) current_limit <= 4'h1;
        wait_oc(0);
        @(posedge clk) current_limit <= 4'h0;
        wait_clk(3);
        chk4("channel_on", 4'h0, channel_on);
        chk1("fault_flag_n_oe", 1'b1, fault_flag_n_oe);
        host.read_bits(rd);
        chk4("fault bits", 4'h1, rd);
        wait_clk(40);
        chk4("overcurrent_flag", 4'h1, overcurrent_flag);
        wait_clk(80);
        chk4("overcurrent_flag", 4'h0, overcurrent_flag);
        chk4("channel_on", 4'h1, channel_on);
        @(posedge clk) current_limit <= 4'h1;
        wait_oc(0);
        host.write_bits(8'h00, 4);
        wait_clk(6);
        chk4("overcurrent_flag", 4'h0, overcurrent_flag);
        @(posedge clk) current_limit <= 4'h0;
        $display("test overcurrent done");

        @(posedge clk) open_load_sense <= 4'h2;
        wait_clk(10);
        chk4("open_load_flag", 4'h0, open_load_flag);
        wait_clk(30);
        chk4("open_load_flag", 4'h2, open_load_flag);
        chk1("fault_flag_n_oe", 1'b1, fault_flag_n_oe);
        host.read_bits(rd);
        chk4("fault bits", 4'h2, rd);
        host.write_bits(8'h02, 4);
        wait_clk(6);
        chk4("open_load_flag", 4'h0, open_load_flag);
        @(posedge clk) open_load_sense <= 4'h0;
        $display("test open load done");

        @(posedge clk) thermal_shutdown <= 1'b1;
        wait_clk(6);
        chk4("channel_on", 4'h0, channel_on);
        chk1("fault_flag_n_oe", 1'b1, fault_flag_n_oe);
        chk1("fault_flag_n_out", 1'b0, fault_flag_n_out);
        @(posedge clk) thermal_shutdown <= 1'b0;
        wait_clk(6);
        chk4("channel_on", 4'h2, channel_on);
        chk1("fault_flag_n_oe", 1'b0, fault_flag_n_oe);
        $display("test thermal done");

        host.write_bits(8'h0F, 4);
        @(posedge clk) current_limit <= 4'h2;
        wait_oc(1);
        @(posedge clk) device_reset <= 1'b1;
        wait_clk(6);
        chk4("overcurrent_flag", 4'h0, overcurrent_flag);
        chk4("channel_on", 4'h0, channel_on);
        chk1("sdo", 1'b0, serial_data_out);
        @(posedge clk) device_reset <= 1'b0;
        current_limit <= 4'h0;
        wait_clk(10);
        host.write_bits(8'h0F, 4);
        @(posedge clk) undervoltage_lockout <= 1'b1;
        wait_clk(6);
        chk4("channel_on", 4'h0, channel_on);
        chk1("sdo", 1'b0, serial_data_out);
        @(posedge clk) undervoltage_lockout <= 1'b0;
        wait_clk(10);
        host.write_bits(8'h05, 4);
        wait_clk(4);
        chk4("channel_on", 4'h5, channel_on);
        $display("test resets done");
        stop_test();
    end
endmodule : serial_lowside_driver_ctrl_tb
